// file: src/mcud_pkg.sv
package mcud_pkg;
  // =====================================================
  // opcode fields
  localparam logic [3:0] NIB_BIT_CLEAR = 4'h9;
  localparam logic [3:0] NIB_BIT_SET = 4'h8;
  localparam logic [3:0] NIB_BIT_TOGGLE = 4'h7;
  localparam logic [3:0] NIB_SKIP_CLEAR = 4'hb;
  localparam logic [3:0] NIB_SKIP_SET = 4'ha;
  localparam logic [3:0] NIB_BRANCH = 4'hd;
  localparam logic [3:0] NIB_CONTROL = 4'he;
  localparam logic [3:0] NIB_FILLER = 4'hf;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [7:0] UB_ADD = 8'h0f;
  localparam logic [7:0] UB_SUB = 8'h08;
  localparam logic [7:0] UB_AND = 8'h0b;
  localparam logic [7:0] UB_OR = 8'h09;
  localparam logic [7:0] UB_XOR = 8'h0a;
  localparam logic [7:0] UB_RET_LIT = 8'h0c;
  localparam logic [7:0] UB_BANK = 8'h01;
  localparam logic [7:0] UB_JUMP = 8'hef;
  localparam logic [7:0] UB_POINTER = 8'hee;
  localparam logic [2:0] CALL_CODE = 3'h6;
  localparam logic [15:0] W_WDT_CLEAR = 16'h0004;
  localparam logic [15:0] W_POP = 16'h0006;
  localparam logic [15:0] W_PUSH = 16'h0005;
  localparam logic [15:0] W_RESET = 16'h00ff;
  localparam logic [15:0] W_STANDBY = 16'h0003;
  localparam logic [14:0] W_IRQ_RET_HI = 15'h0008;
  localparam logic [14:0] W_RETURN_HI = 15'h0009;
  localparam logic [11:0] W_TABLE_HI = 12'h000;
  // =====================================================
  // branch condition select, bits 10:9 of the word
  localparam logic [1:0] COND_ZERO = 2'h0;
  localparam logic [1:0] COND_CARRY = 2'h1;
  localparam logic [1:0] COND_OVERFLOW = 2'h2;
  localparam logic [1:0] COND_NEGATIVE = 2'h3;
  // =====================================================
  // decoded operation classes
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_BIT_CLEAR = 5'h01, OP_BIT_SET = 5'h02,
    OP_BIT_TOGGLE = 5'h03, OP_SKIP_CLEAR = 5'h04, OP_SKIP_SET = 5'h05,
    OP_BRANCH_COND = 5'h06, OP_BRANCH_ALWAYS = 5'h07, OP_CALL = 5'h08,
    OP_JUMP = 5'h09, OP_WDT_CLEAR = 5'h0a, OP_POP = 5'h0b,
    OP_PUSH = 5'h0c, OP_RESET = 5'h0d, OP_IRQ_RETURN = 5'h0e,
    OP_RETURN = 5'h0f, OP_RET_LIT = 5'h10, OP_STANDBY = 5'h11,
    OP_AND = 5'h12, OP_OR = 5'h13, OP_XOR = 5'h14, OP_ADD = 5'h15,
    OP_SUB = 5'h16, OP_POINTER_LOAD = 5'h17, OP_BANK_LOAD = 5'h18,
    OP_TABLE_READ = 5'h19, OP_TABLE_WRITE = 5'h1a, OP_OTHER = 5'h1b
  } mcud_op_type;
  typedef enum logic [3:0] {
    ST_EXEC = 4'h1, ST_OPERAND = 4'h2, ST_FLUSH = 4'h4, ST_STALL = 4'h8
  } mcud_state_type;
  typedef struct packed {
    logic carry;
    logic digitCarry;
    logic zero;
    logic overflow;
    logic negative;
  } mcud_flags_type;
  typedef struct packed {
    mcud_op_type op;
    logic [2:0] bitIndex;
    logic access;
    logic [7:0] fileAddr;
    logic [7:0] literal;
    logic [10:0] offset;
    logic [19:0] target;
    logic fastSave;
    logic [1:0] pointerIndex;
    logic [11:0] pointerLiteral;
    logic tableWrite;
    logic [1:0] tableMode;
    mcud_flags_type flagMask;
  } mcud_decoded_type;
  localparam mcud_flags_type FLAGS_NONE = '{default: 1'b0};
  localparam mcud_flags_type FLAGS_ARITH = '{default: 1'b1};
  localparam mcud_flags_type FLAGS_LOGIC = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
endpackage

// file: src/mcud_decoder.sv
// Function
// - port rewrite uses pin levels, not latch
// - timer zero modify clears assigned prescaler
// - pc change or true test: two cycles, three for a true test that skips a two-word op
// - lone second word executes as no-operation
// - top nibble all ones is nop
// - bit test skip decode, skip costs cycles
// - conditional branch decode, taken costs two
// - unconditional relative branch, two cycles, flagless
// - two-word absolute call with fast save
// - two-word absolute jump, two cycles
// - watchdog clear word, updates timeout/powerdown
// - stack pop and push words, flagless
// - software reset word, one cycle
// - interrupt return pops, re-enables interrupts
// - subroutine return pops, optional fast restore
// - return with literal into working register
// - standby word, updates timeout/powerdown
// - literal and/or/xor, zero and negative
// - literal add/subtract, all arithmetic flags
// - two-word pointer literal load
// - bank literal load into low nibble
// - table read/write pointer modes, two cycles
`timescale 1ns/1ps
module mcud_decoder (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // instruction word from program memory
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  output logic fetchReady,
  // datapath state seen at decode
  input wire mcud_pkg::mcud_flags_type aluFlags,
  input wire logic testedBit,
  input wire logic targetIsPort,
  input wire logic targetIsTimerZero,
  input wire logic prescalerAssigned,
  // decoded operation
  output mcud_pkg::mcud_decoded_type decoded,
  output logic opStrobe,
  output logic flushNop,
  // side effects, one-cycle pulses
  output logic usePinLevels,
  output logic prescalerClear,
  output logic watchdogClear,
  output logic standbyEnter,
  output logic timeoutPowerdownUpdate,
  output logic softReset,
  output logic stackPop,
  output logic stackPush,
  output logic irqEnableRestore,
  output logic fastRestore,
  output logic workingLoadLiteral
);

  // =====================================================
  // word fields
  wire [3:0] topNib = instrWord[15:12];
  wire [7:0] upperByte = instrWord[15:8];
  wire [7:0] lowByte = instrWord[7:0];
  wire wordTaken = instrValid && fetchReady;

  // =====================================================
  // opcode recognisers
  // control nibble splits further on bit 11 and on the whole upper byte
  wire isFiller = topNib == mcud_pkg::NIB_FILLER;
  wire isBitClr = topNib == mcud_pkg::NIB_BIT_CLEAR;
  wire isBitSet = topNib == mcud_pkg::NIB_BIT_SET;
  wire isBitTgl = topNib == mcud_pkg::NIB_BIT_TOGGLE;
  wire isSkipClr = topNib == mcud_pkg::NIB_SKIP_CLEAR;
  wire isSkipSet = topNib == mcud_pkg::NIB_SKIP_SET;
  wire isBra = topNib == mcud_pkg::NIB_BRANCH && !instrWord[11];
  wire isCtl = topNib == mcud_pkg::NIB_CONTROL;
  wire isCond = isCtl && !instrWord[11];
  wire isCall = isCtl && instrWord[11:9] == mcud_pkg::CALL_CODE;
  wire isJump = upperByte == mcud_pkg::UB_JUMP;
  wire isPtr = upperByte == mcud_pkg::UB_POINTER && instrWord[7:6] == 2'h0;
  wire isAdd = upperByte == mcud_pkg::UB_ADD;
  wire isSub = upperByte == mcud_pkg::UB_SUB;
  wire isAnd = upperByte == mcud_pkg::UB_AND;
  wire isOr = upperByte == mcud_pkg::UB_OR;
  wire isXor = upperByte == mcud_pkg::UB_XOR;
  wire isRetLit = upperByte == mcud_pkg::UB_RET_LIT;
  wire isBank = upperByte == mcud_pkg::UB_BANK && instrWord[7:4] == 4'h0;
  wire isWdt = instrWord == mcud_pkg::W_WDT_CLEAR;
  wire isPop = instrWord == mcud_pkg::W_POP;
  wire isPush = instrWord == mcud_pkg::W_PUSH;
  wire isReset = instrWord == mcud_pkg::W_RESET;
  wire isStandby = instrWord == mcud_pkg::W_STANDBY;
  wire isIrqRet = instrWord[15:1] == mcud_pkg::W_IRQ_RET_HI;
  wire isReturn = instrWord[15:1] == mcud_pkg::W_RETURN_HI;
  wire isTable = instrWord[15:4] == mcud_pkg::W_TABLE_HI && instrWord[3];
  wire isNopWord = instrWord == 16'h0000;

  // =====================================================
  // condition evaluation
  // branch sense: bit 8 set means branch on flag clear
  wire condFlag = instrWord[10:9] == mcud_pkg::COND_ZERO ? aluFlags.zero
                : instrWord[10:9] == mcud_pkg::COND_CARRY ? aluFlags.carry
                : instrWord[10:9] == mcud_pkg::COND_OVERFLOW ? aluFlags.overflow
                : aluFlags.negative;
  wire branchTaken = isCond && (condFlag != instrWord[8]);
  wire skipTaken = (isSkipClr && !testedBit) || (isSkipSet && testedBit);
  // a skip drops the next word; a skipped two-word first word leaves its
  // filler second word, which decodes as a nop, giving the third cycle
  wire bitModify = isBitClr || isBitSet || isBitTgl;
  wire twoWordFirst = isCall || isJump || isPtr;
  wire pcChange = isBra || branchTaken || skipTaken || isIrqRet
                || isReturn || isRetLit;

  // =====================================================
  // operation class, filler nibble checked first
  wire mcud_pkg::mcud_op_type wordOp =
      isFiller ? mcud_pkg::OP_NOP
    : isBitClr ? mcud_pkg::OP_BIT_CLEAR
    : isBitSet ? mcud_pkg::OP_BIT_SET
    : isBitTgl ? mcud_pkg::OP_BIT_TOGGLE
    : isSkipClr ? mcud_pkg::OP_SKIP_CLEAR
    : isSkipSet ? mcud_pkg::OP_SKIP_SET
    : isBra ? mcud_pkg::OP_BRANCH_ALWAYS
    : isCond ? mcud_pkg::OP_BRANCH_COND
    : isCall ? mcud_pkg::OP_CALL
    : isJump ? mcud_pkg::OP_JUMP
    : isPtr ? mcud_pkg::OP_POINTER_LOAD
    : isAdd ? mcud_pkg::OP_ADD
    : isSub ? mcud_pkg::OP_SUB
    : isAnd ? mcud_pkg::OP_AND
    : isOr ? mcud_pkg::OP_OR
    : isXor ? mcud_pkg::OP_XOR
    : isRetLit ? mcud_pkg::OP_RET_LIT
    : isBank ? mcud_pkg::OP_BANK_LOAD
    : isWdt ? mcud_pkg::OP_WDT_CLEAR
    : isPop ? mcud_pkg::OP_POP
    : isPush ? mcud_pkg::OP_PUSH
    : isReset ? mcud_pkg::OP_RESET
    : isStandby ? mcud_pkg::OP_STANDBY
    : isIrqRet ? mcud_pkg::OP_IRQ_RETURN
    : isReturn ? mcud_pkg::OP_RETURN
    : isTable && instrWord[2] ? mcud_pkg::OP_TABLE_WRITE
    : isTable ? mcud_pkg::OP_TABLE_READ
    : isNopWord ? mcud_pkg::OP_NOP
    : mcud_pkg::OP_OTHER;

  // flags that the op may update; everything else leaves status alone
  wire mcud_pkg::mcud_flags_type wordMask =
      (isAdd || isSub) ? mcud_pkg::FLAGS_ARITH
    : (isAnd || isOr || isXor) ? mcud_pkg::FLAGS_LOGIC
    : mcud_pkg::FLAGS_NONE;

  // =====================================================
  // field extraction for a first or single word
  mcud_pkg::mcud_decoded_type wordFields;
  always_comb begin
    wordFields = '0;
    wordFields.op = wordOp;
    wordFields.bitIndex = instrWord[11:9];
    wordFields.access = instrWord[8];
    wordFields.fileAddr = lowByte;
    wordFields.literal = isBank ? {4'h0, instrWord[3:0]} : lowByte;
    wordFields.offset = isBra ? instrWord[10:0]
                      : {{3{instrWord[7]}}, lowByte};
    wordFields.target = {12'h000, lowByte};
    wordFields.fastSave = isCall ? instrWord[8] : instrWord[0];
    wordFields.pointerIndex = instrWord[5:4];
    wordFields.pointerLiteral = {instrWord[3:0], 8'h00};
    wordFields.tableWrite = instrWord[2];
    wordFields.tableMode = instrWord[1:0];
    wordFields.flagMask = wordMask;
  end

  // =====================================================
  // pending first word, completed by the operand word
  mcud_pkg::mcud_decoded_type pending;
  mcud_pkg::mcud_decoded_type merged;
  // operand word fills the upper target bits or the low literal byte
  always_comb begin
    merged = pending;
    merged.target = {instrWord[11:0], pending.target[7:0]};
    merged.pointerLiteral = {pending.pointerLiteral[11:8], lowByte};
  end

  // =====================================================
  // sequencing
  mcud_pkg::mcud_state_type state;
  mcud_pkg::mcud_state_type next_state;
  // operand wait, flush slot and table stall each cover one word slot
  always_comb begin
    next_state = state;
    case (state)
      mcud_pkg::ST_EXEC: begin
        if (wordTaken && twoWordFirst) begin
          next_state = mcud_pkg::ST_OPERAND;
        end else if (wordTaken && pcChange) begin
          next_state = mcud_pkg::ST_FLUSH;
        end else if (wordTaken && isTable) begin
          next_state = mcud_pkg::ST_STALL;
        end
      end
      mcud_pkg::ST_OPERAND: begin
        if (wordTaken) begin
          next_state = mcud_pkg::ST_EXEC;
        end
      end
      mcud_pkg::ST_FLUSH: begin
        if (wordTaken) begin
          next_state = mcud_pkg::ST_EXEC;
        end
      end
      mcud_pkg::ST_STALL: begin
        // fetchReady is low here, so no word can slip in
        next_state = mcud_pkg::ST_EXEC;
      end
      default: begin
        next_state = mcud_pkg::ST_EXEC;
      end
    endcase
  end

  // =====================================================
  // next values of the outputs
  // split the accepted word by state; a flushed word starts no side effect
  wire inExec = wordTaken && state == mcud_pkg::ST_EXEC;
  wire inOperand = wordTaken && state == mcud_pkg::ST_OPERAND;
  wire inFlush = wordTaken && state == mcud_pkg::ST_FLUSH;
  wire next_opStrobe = (inExec && !twoWordFirst) || inOperand;
  wire next_fetchReady = next_state != mcud_pkg::ST_STALL;
  wire next_usePinLevels = inExec && bitModify && targetIsPort;
  wire next_prescalerClear = inExec && bitModify && targetIsTimerZero
                           && prescalerAssigned;
  wire next_watchdogClear = inExec && isWdt;
  wire next_standbyEnter = inExec && isStandby;
  wire next_softReset = inExec && isReset;
  wire next_stackPop = inExec && (isPop || isIrqRet || isReturn || isRetLit);
  wire next_stackPush = inExec && isPush;
  wire next_irqEnableRestore = inExec && isIrqRet;
  wire next_fastRestore = inExec && (isIrqRet || isReturn) && instrWord[0];
  wire next_workingLoad = inExec && isRetLit;
  // a lone filler or a flushed word still reports as a plain nop
  wire mcud_pkg::mcud_decoded_type next_decoded =
      inOperand ? merged : inExec ? wordFields : '0;

  // =====================================================
  // state and pending word registers
  // pending loads only in exec, so an operand word never overwrites it
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= mcud_pkg::ST_EXEC;
      pending <= '0;
    end else begin
      state <= next_state;
      pending <= (inExec && twoWordFirst) ? wordFields : pending;
    end
  end

  // =====================================================
  // output registers for decoded, opStrobe, flushNop and fetchReady; the side-effect pulses come from the block below
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      decoded <= '0;
      opStrobe <= 1'b0;
      flushNop <= 1'b0;
      fetchReady <= 1'b1;
    end else begin
      decoded <= next_decoded;
      opStrobe <= next_opStrobe;
      flushNop <= inFlush || state == mcud_pkg::ST_STALL;
      fetchReady <= next_fetchReady;
    end
  end

  // side-effect pulses, one cycle after the word is taken
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      usePinLevels <= 1'b0;
      prescalerClear <= 1'b0;
      watchdogClear <= 1'b0;
      standbyEnter <= 1'b0;
      timeoutPowerdownUpdate <= 1'b0;
      softReset <= 1'b0;
      stackPop <= 1'b0;
      stackPush <= 1'b0;
      irqEnableRestore <= 1'b0;
      fastRestore <= 1'b0;
      workingLoadLiteral <= 1'b0;
    end else begin
      usePinLevels <= next_usePinLevels;
      prescalerClear <= next_prescalerClear;
      watchdogClear <= next_watchdogClear;
      standbyEnter <= next_standbyEnter;
      timeoutPowerdownUpdate <= next_watchdogClear || next_standbyEnter;
      softReset <= next_softReset;
      stackPop <= next_stackPop;
      stackPush <= next_stackPush;
      irqEnableRestore <= next_irqEnableRestore;
      fastRestore <= next_fastRestore;
      workingLoadLiteral <= next_workingLoad;
    end
  end

endmodule

// file: verification/mcud_prog_mem.sv
`timescale 1ns/1ps
// =====================================================
// program memory model feeding the decoder
module mcud_prog_mem (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // fetch handshake
  input wire logic fetchReady,
  output logic instrValid,
  output logic [15:0] instrWord,
  // bench control
  input wire logic run,
  input wire logic slow
);
  logic [15:0] mem [0:31];  // program, loaded by the bench
  int count = 0;  // words in the program
  int pc = 0;  // next word to offer
  logic gap = 1'b0;  // idle slot after a taken word, slow mode
  initial instrWord = 16'h0000;
  initial instrValid = 1'b0;
  // offer off the sampling edge; idle bus keeps moving so no stale word looks real
  always @(negedge clock) begin
    if (!rst_b || !run || pc >= count || gap) begin
      instrValid <= 1'b0;
      instrWord <= ~instrWord;
    end else begin
      instrValid <= 1'b1;
      instrWord <= mem[pc];
    end
  end
  // word held until taken, then advance
  always @(posedge clock) begin
    if (!run) begin
      pc <= 0;
    end else if (instrValid && fetchReady) begin
      pc <= pc + 1;
    end
    gap <= slow && instrValid && fetchReady;
  end
endmodule

// file: verification/mcud_decoder_chk.sv
`timescale 1ns/1ps
// =====================================================
// port checker for the decoder
module mcud_decoder_chk (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // fetch side
  input wire logic instrValid,
  input wire logic fetchReady,
  input wire logic testedBit,
  input wire logic targetIsTimerZero,
  input wire logic prescalerAssigned,
  // decode results
  input wire mcud_pkg::mcud_decoded_type decoded,
  input wire logic opStrobe,
  input wire logic flushNop,
  input wire logic prescalerClear,
  input wire logic watchdogClear,
  input wire logic timeoutPowerdownUpdate,
  input wire logic stackPop,
  input wire logic workingLoadLiteral
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire logic take = instrValid && fetchReady;  // word taken at this edge
  // single-word op that moves the program counter; call and jump use their operand slot
  sequence s_pc_move;
    opStrobe && decoded.op inside {mcud_pkg::OP_IRQ_RETURN,
      mcud_pkg::OP_BRANCH_ALWAYS, mcud_pkg::OP_RETURN, mcud_pkg::OP_RET_LIT};
  endsequence
  // bit test whose condition held when its word was taken
  sequence s_skip_true;
    opStrobe && ((decoded.op == mcud_pkg::OP_SKIP_CLEAR && !$past(testedBit)) ||
      (decoded.op == mcud_pkg::OP_SKIP_SET && $past(testedBit)));
  endsequence
  a_ready_one: assert property (!fetchReady |=> fetchReady)
    else $error("fetch stall longer than one cycle");
  a_table_stall: assert property (opStrobe &&
    decoded.op inside {mcud_pkg::OP_TABLE_READ, mcud_pkg::OP_TABLE_WRITE} |->
    !fetchReady ##1 (flushNop && !opStrobe))
    else $error("table op without a stall cycle");
  a_pc_flush: assert property (s_pc_move ##0 take |=> flushNop && !opStrobe)
    else $error("word after pc change not flushed");
  a_skip_flush: assert property (s_skip_true ##0 take |=> flushNop && !opStrobe)
    else $error("skipped word executed");
  a_wdt_status: assert property (watchdogClear |-> opStrobe &&
    timeoutPowerdownUpdate && decoded.op == mcud_pkg::OP_WDT_CLEAR)
    else $error("watchdog clear without status update");
  a_logic_flags: assert property (opStrobe && decoded.op inside {mcud_pkg::OP_AND,
    mcud_pkg::OP_OR, mcud_pkg::OP_XOR} |-> decoded.flagMask == mcud_pkg::FLAGS_LOGIC)
    else $error("logic literal flag mask wrong");
  a_arith_flags: assert property (opStrobe && decoded.op inside {mcud_pkg::OP_ADD,
    mcud_pkg::OP_SUB} |-> decoded.flagMask == mcud_pkg::FLAGS_ARITH)
    else $error("arithmetic literal flag mask wrong");
  a_filler_nop: assert property (opStrobe && decoded.op == mcud_pkg::OP_NOP |->
    decoded.flagMask == mcud_pkg::FLAGS_NONE && !timeoutPowerdownUpdate)
    else $error("no-operation touches status");
  a_ret_literal: assert property (opStrobe && decoded.op == mcud_pkg::OP_RET_LIT |->
    workingLoadLiteral && stackPop)
    else $error("return with literal incomplete");
  a_prescaler_clr: assert property (prescalerClear |-> opStrobe &&
    $past(targetIsTimerZero) && $past(prescalerAssigned))
    else $error("prescaler cleared without cause");
  a_two_word: assert property (opStrobe &&
    decoded.op inside {mcud_pkg::OP_JUMP, mcud_pkg::OP_CALL, mcud_pkg::OP_POINTER_LOAD}
    |-> !$past(opStrobe))
    else $error("two-word op completed without its first-word cycle");
endmodule
bind mcud_decoder mcud_decoder_chk u_chk (.clock(clock), .rst_b(rst_b),
  .instrValid(instrValid), .fetchReady(fetchReady), .testedBit(testedBit),
  .targetIsTimerZero(targetIsTimerZero), .prescalerAssigned(prescalerAssigned),
  .decoded(decoded), .opStrobe(opStrobe), .flushNop(flushNop),
  .prescalerClear(prescalerClear), .watchdogClear(watchdogClear),
  .timeoutPowerdownUpdate(timeoutPowerdownUpdate), .stackPop(stackPop),
  .workingLoadLiteral(workingLoadLiteral));

// file: verification/test_mcu_instruction_decoder.sv
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_mcu_instruction_decoder;
  // =====================================================
  // stimulus and observed state
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic run = 1'b0;  // memory model offers words
  logic slow = 1'b0;  // memory model idles between words
  logic testedBit = 1'b0;
  logic targetIsPort = 1'b0;
  logic targetIsTimerZero = 1'b0;
  logic prescalerAssigned = 1'b0;
  mcud_pkg::mcud_flags_type aluFlags = '0;
  logic instrValid, fetchReady, opStrobe, flushNop;
  logic [15:0] instrWord;
  mcud_pkg::mcud_decoded_type decoded;
  wire [10:0] pulses;  // side-effect pulses packed for compares
  mcud_pkg::mcud_decoded_type got[$];  // completed ops of a run
  logic [10:0] gotPul[$];  // their pulses
  int flushes = 0;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  mcud_prog_mem u_mem (.clock(clock), .rst_b(rst_b), .fetchReady(fetchReady),
    .instrValid(instrValid), .instrWord(instrWord), .run(run), .slow(slow));
  mcud_decoder u_dut (.clock(clock), .rst_b(rst_b), .instrValid(instrValid),
    .instrWord(instrWord), .fetchReady(fetchReady), .aluFlags(aluFlags),
    .testedBit(testedBit), .targetIsPort(targetIsPort), .targetIsTimerZero(targetIsTimerZero),
    .prescalerAssigned(prescalerAssigned), .decoded(decoded), .opStrobe(opStrobe),
    .flushNop(flushNop), .usePinLevels(pulses[10]), .prescalerClear(pulses[9]),
    .watchdogClear(pulses[8]), .standbyEnter(pulses[7]), .timeoutPowerdownUpdate(pulses[6]),
    .softReset(pulses[5]), .stackPop(pulses[4]), .stackPush(pulses[3]),
    .irqEnableRestore(pulses[2]), .fastRestore(pulses[1]), .workingLoadLiteral(pulses[0]));
  // =====================================================
  // clock, hang guard and output monitor
  initial forever #5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      $display("[ERR] %0t timeout", $time);
      conclude();
    end
  end
  // sample on the falling edge, outputs long settled
  always @(negedge clock) begin
    if (opStrobe === 1'b1) begin
      got.push_back(decoded);
      gotPul.push_back(pulses);
    end
    if (flushNop === 1'b1) flushes++;
  end
  // load a program, run it, let the pipeline drain
  task automatic exec(input logic [15:0] w[$]);
    int t;
    got.delete();
    gotPul.delete();
    flushes = 0;
    foreach (w[i]) u_mem.mem[i] = w[i];
    u_mem.count = w.size();
    run <= 1'b1;
    for (t = 0; t < 100 && u_mem.pc < w.size(); t++) @(negedge clock);
    if (t == 100) begin
      n_errors++;
      $display("[ERR] %0t program not consumed", $time);
    end
    repeat (4) @(negedge clock);
    run <= 1'b0;
    @(negedge clock);
  endtask
  // =====================================================
  // one-word literal and control ops, returns flush their successor
  task automatic t_single();
    mcud_pkg::mcud_op_type e[14] = '{mcud_pkg::OP_ADD, mcud_pkg::OP_SUB, mcud_pkg::OP_AND,
      mcud_pkg::OP_OR, mcud_pkg::OP_XOR, mcud_pkg::OP_BANK_LOAD, mcud_pkg::OP_WDT_CLEAR,
      mcud_pkg::OP_STANDBY, mcud_pkg::OP_POP, mcud_pkg::OP_PUSH, mcud_pkg::OP_RET_LIT,
      mcud_pkg::OP_IRQ_RETURN, mcud_pkg::OP_RETURN, mcud_pkg::OP_RESET};
    logic [10:0] p[14] = '{11'h000, 11'h000, 11'h000, 11'h000, 11'h000, 11'h000, 11'h140,
      11'h0c0, 11'h010, 11'h008, 11'h011, 11'h016, 11'h012, 11'h020};
    exec('{16'h0f12, 16'h0812, 16'h0b34, 16'h0934, 16'h0a56, 16'h0105, 16'h0004, 16'h0003,
      16'h0006, 16'h0005, 16'h0c78, 16'h0000, 16'h0011, 16'h0000, 16'h0013, 16'h0000,
      16'h00ff});
    `CHK(flushes, 3)
    `CHK(got[10].literal, 8'h78)
    `CHK(got[5].literal, 8'h05)
    for (int i = 0; i < 14; i++) begin
      `CHK(got[i].op, e[i])
      `CHK(gotPul[i], p[i])
    end
  endtask
  // two-word ops, and a second word met on its own; the words are the two cycles
  task automatic t_twoword();
    exec('{16'hef12, 16'hf345, 16'h0000, 16'hed56, 16'hf789, 16'h0000, 16'hee2a, 16'hf0bc,
      16'hf123});
    `CHK(got[0].op, mcud_pkg::OP_JUMP)
    `CHK(got[0].target, 20'h34512)
    `CHK(got[2].op, mcud_pkg::OP_CALL)
    `CHK(got[2].target, 20'h78956)
    `CHK(got[2].fastSave, 1'b1)
    `CHK(got[4].pointerIndex, 2'h2)
    `CHK(got[4].pointerLiteral, 12'habc)
    `CHK(got[5].op, mcud_pkg::OP_NOP)
    `CHK(flushes, 0)
  endtask
  // bit modify on a port and on the timer, slow memory
  task automatic t_bits();
    targetIsPort = 1'b1;
    targetIsTimerZero = 1'b1;
    prescalerAssigned = 1'b1;
    slow = 1'b1;
    exec('{16'h97ab, 16'h87ab, 16'h77ab});
    `CHK(got[0].op, mcud_pkg::OP_BIT_CLEAR)
    `CHK(got[1].op, mcud_pkg::OP_BIT_SET)
    `CHK(got[2].op, mcud_pkg::OP_BIT_TOGGLE)
    `CHK({got[2].bitIndex, got[2].access, got[2].fileAddr}, 12'h7ab)
    `CHK(gotPul[1], 11'h600)
    targetIsPort = 1'b0;
    prescalerAssigned = 1'b0;
    slow = 1'b0;
    exec('{16'h97ab});
    `CHK(gotPul[0], 11'h000)
    targetIsTimerZero = 1'b0;
  endtask
  // bit test skips, including over a two-word op
  task automatic t_skip();
    exec('{16'hb000, 16'h0f01});
    `CHK(got.size(), 1)
    testedBit = 1'b1;
    exec('{16'hb000, 16'h0f01});
    `CHK(got.size(), 2)
    exec('{16'ha000, 16'h0f01});
    `CHK(flushes, 1)
    testedBit = 1'b0;
    exec('{16'hb000, 16'hef12, 16'hf345});
    `CHK(got[1].op, mcud_pkg::OP_NOP)
  endtask
  // every condition code both ways, then the unconditional branch
  task automatic t_branch();
    for (int f = 0; f < 2; f++) begin
      for (int k = 0; k < 8; k++) begin
        aluFlags = f[0] ? 5'h1f : 5'h00;
        exec('{16'he0fe | 16'(k << 8), 16'h0000});
        `CHK(got.size(), (f[0] ^ k[0]) ? 1 : 2)
        `CHK(got[0].offset, 11'h7fe)
      end
    end
    exec('{16'hd7ff, 16'h0000});
    `CHK(got[0].op, mcud_pkg::OP_BRANCH_ALWAYS)
    `CHK(got[0].offset, 11'h7ff)
    `CHK(flushes, 1)
  endtask
  // all table read and write pointer modes back to back
  task automatic t_table();
    exec('{16'h0008, 16'h0009, 16'h000a, 16'h000b, 16'h000c, 16'h000d, 16'h000e, 16'h000f});
    `CHK(flushes, 8)
    for (int i = 0; i < 8; i++) begin
      `CHK({got[i].tableWrite, got[i].tableMode}, 3'(i))
    end
  endtask
  task automatic conclude();
    if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // =====================================================
  // main sequence
  initial begin
    repeat (8) @(negedge clock);
    `CHK(fetchReady, 1'b1)
    rst_b = 1'b1;
    @(negedge clock);
    t_single();
    t_twoword();
    t_bits();
    t_skip();
    t_branch();
    t_table();
    conclude();
  end
endmodule
